// [rtl/fcd_pkg.sv]
package fcd_pkg;

  // ==========================================================================
  // command codes
  localparam logic [7:0] FCD_CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] FCD_CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] FCD_CMD_READ_ID      = 8'h90;
  localparam logic [7:0] FCD_CMD_READ_QUERY   = 8'h98;
  localparam logic [7:0] FCD_CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] FCD_CMD_PROG_SETUP   = 8'h40;
  localparam logic [7:0] FCD_CMD_PROG_ALT     = 8'h10;
  localparam logic [7:0] FCD_CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] FCD_CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] FCD_CMD_SUSPEND      = 8'hB0;
  localparam logic [7:0] FCD_CMD_LOCK_SETUP   = 8'h60;
  localparam logic [7:0] FCD_CMD_LOCK_BLOCK   = 8'h01;
  localparam logic [7:0] FCD_CMD_LOCK_DOWN    = 8'h2F;
  localparam logic [7:0] FCD_CMD_PROT_SETUP   = 8'hC0;
  localparam logic [7:0] FCD_CMD_SET_CONFIG   = 8'h03;

  // ==========================================================================
  // data, addresses and widths
  localparam int          FCD_AW               = 24;
  localparam int          FCD_DW               = 16;
  localparam logic [15:0] FCD_PROT_LOCK_VALUE  = 16'hFFFD;
  localparam logic [23:0] FCD_LOCK_PROT_ADDR   = 24'h00_0080;
  localparam logic [23:0] FCD_PROT_WORD_BASE   = 24'h00_0081;
  localparam logic [1:0]  FCD_PROT_WORD_LAST   = 2'h3;
  localparam logic [15:0] FCD_ZERO16           = 16'h0000;
  localparam logic [23:0] FCD_ZERO24           = 24'h00_0000;

  // ==========================================================================
  // write strobe timing at 40 MHz (25 ns period)
  localparam int          FCD_CLK_NS           = 25;
  localparam int          FCD_ADDR_NS          = 25;
  localparam int          FCD_WE_NS            = 50;
  localparam int          FCD_HOLD_NS          = 25;
  localparam logic [3:0]  FCD_ADDR_CYC = 4'(((FCD_ADDR_NS + FCD_CLK_NS - 1) / FCD_CLK_NS));
  localparam logic [3:0]  FCD_WE_CYC   = 4'(((FCD_WE_NS + FCD_CLK_NS - 1) / FCD_CLK_NS));
  localparam logic [3:0]  FCD_HOLD_CYC = 4'(((FCD_HOLD_NS + FCD_CLK_NS - 1) / FCD_CLK_NS));
  localparam logic [3:0]  FCD_ONE4     = 4'h1;

  // ==========================================================================
  // host operations
  typedef enum logic [3:0] {
    FCD_OP_READ_ARRAY  = 4'h0,
    FCD_OP_READ_STATUS = 4'h1,
    FCD_OP_READ_ID     = 4'h2,
    FCD_OP_READ_QUERY  = 4'h3,
    FCD_OP_CLEAR       = 4'h4,
    FCD_OP_PROGRAM     = 4'h5,
    FCD_OP_ERASE       = 4'h6,
    FCD_OP_SUSPEND     = 4'h7,
    FCD_OP_RESUME      = 4'h8,
    FCD_OP_LOCK        = 4'h9,
    FCD_OP_UNLOCK      = 4'hA,
    FCD_OP_LOCK_DOWN   = 4'hB,
    FCD_OP_PROT_PROG   = 4'hC,
    FCD_OP_PROT_LOCK   = 4'hD,
    FCD_OP_SET_CONFIG  = 4'hE
  } fcd_op_t;

  // ==========================================================================
  // one-hot sequencer states
  typedef enum logic [3:0] {
    FCD_ST_IDLE  = 4'b0001,
    FCD_ST_CYC1  = 4'b0010,
    FCD_ST_CYC2  = 4'b0100,
    FCD_ST_DONE  = 4'b1000
  } fcd_state_t;

  typedef enum logic [3:0] {
    FCD_WS_IDLE  = 4'b0001,
    FCD_WS_ADDR  = 4'b0010,
    FCD_WS_WE    = 4'b0100,
    FCD_WS_HOLD  = 4'b1000
  } fcd_wstate_t;

endpackage

// [rtl/fcd_write_cycle.sv]
module fcd_write_cycle
  import fcd_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // request
  input  wire logic              start_i,
  input  wire logic [FCD_AW-1:0] addr_i,
  input  wire logic [FCD_DW-1:0] data_i,
  output logic                   done_o,
  // flash pins
  output logic                   ce_n_o,
  output logic                   we_n_o,
  output logic                   oe_n_o,
  output logic                   address_valid_n_o,
  output logic [FCD_AW-1:0]      adq_o,
  output logic                   adq_oe_n_o
);

  // ==========================================================================
  // state
  fcd_wstate_t       state_ff, nxt_state;
  logic [3:0]        cnt_ff, nxt_cnt;
  logic              done_ff, nxt_done;
  logic              ce_n_ff, nxt_ce_n;
  logic              we_n_ff, nxt_we_n;
  logic              adv_n_ff, nxt_adv_n;
  logic              oe_adq_n_ff, nxt_oe_adq_n;
  logic [FCD_AW-1:0] adq_ff, nxt_adq;
  logic [FCD_DW-1:0] data_ff, nxt_data;

  // ==========================================================================
  // address phase, then data phase on the shared low lines
  always_comb begin
    nxt_state    = state_ff;
    nxt_cnt      = cnt_ff;
    nxt_done     = 1'b0;
    nxt_ce_n     = ce_n_ff;
    nxt_we_n     = we_n_ff;
    nxt_adv_n    = adv_n_ff;
    nxt_oe_adq_n = oe_adq_n_ff;
    nxt_adq      = adq_ff;
    nxt_data     = data_ff;
    unique case (state_ff)
      FCD_WS_IDLE: begin
        if (start_i) begin
          nxt_state    = FCD_WS_ADDR;
          nxt_cnt      = FCD_ADDR_CYC;
          nxt_ce_n     = 1'b0;
          nxt_adv_n    = 1'b0;
          nxt_oe_adq_n = 1'b0;
          nxt_adq      = addr_i;
          nxt_data     = data_i;
        end
      end
      FCD_WS_ADDR: begin
        if (cnt_ff == FCD_ONE4) begin
          // address latched on adv rising; then data replaces low bits
          nxt_state = FCD_WS_WE;
          nxt_cnt   = FCD_WE_CYC;
          nxt_adv_n = 1'b1;
          nxt_we_n  = 1'b0;
          nxt_adq   = {adq_ff[FCD_AW-1:FCD_DW], data_ff};
        end else begin
          nxt_cnt = cnt_ff - FCD_ONE4;
        end
      end
      FCD_WS_WE: begin
        if (cnt_ff == FCD_ONE4) begin
          nxt_state = FCD_WS_HOLD;
          nxt_cnt   = FCD_HOLD_CYC;
          nxt_we_n  = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - FCD_ONE4;
        end
      end
      FCD_WS_HOLD: begin
        if (cnt_ff == FCD_ONE4) begin
          // data held past we rising edge before releasing the bus
          nxt_state    = FCD_WS_IDLE;
          nxt_ce_n     = 1'b1;
          nxt_oe_adq_n = 1'b1;
          nxt_done     = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - FCD_ONE4;
        end
      end
      default: nxt_state = FCD_WS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_ff    <= FCD_WS_IDLE;
      cnt_ff      <= 4'h0;
      done_ff     <= 1'b0;
      ce_n_ff     <= 1'b1;
      we_n_ff     <= 1'b1;
      adv_n_ff    <= 1'b1;
      oe_adq_n_ff <= 1'b1;
      adq_ff      <= FCD_ZERO24;
      data_ff     <= FCD_ZERO16;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      done_ff     <= nxt_done;
      ce_n_ff     <= nxt_ce_n;
      we_n_ff     <= nxt_we_n;
      adv_n_ff    <= nxt_adv_n;
      oe_adq_n_ff <= nxt_oe_adq_n;
      adq_ff      <= nxt_adq;
      data_ff     <= nxt_data;
    end
  end

  assign done_o            = done_ff;
  assign ce_n_o            = ce_n_ff;
  assign we_n_o            = we_n_ff;
  assign oe_n_o            = 1'b1;
  assign address_valid_n_o = adv_n_ff;
  assign adq_o             = adq_ff;
  assign adq_oe_n_o        = oe_adq_n_ff;

endmodule

// [rtl/fcd_host.sv]
// ============================================================================
// flash command sequencer, host side
module fcd_host
  import fcd_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // operation request
  input  wire logic              req_i,
  input  wire logic [3:0]        op_i,
  input  wire logic [FCD_AW-1:0] addr_i,
  input  wire logic [FCD_DW-1:0] data_i,
  input  wire logic              alt_setup_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic                   refused_o,
  output logic                   array_ok_o,
  // flash pins
  output logic                   ce_n_o,
  output logic                   we_n_o,
  output logic                   oe_n_o,
  output logic                   address_valid_n_o,
  output logic [FCD_AW-1:0]      adq_o,
  output logic                   adq_oe_n_o
);

  // ==========================================================================
  // per-operation helpers
  function automatic logic is_two_cycle(input logic [3:0] op);
    unique case (op)
      FCD_OP_PROGRAM, FCD_OP_ERASE, FCD_OP_LOCK, FCD_OP_UNLOCK, FCD_OP_LOCK_DOWN,
      FCD_OP_PROT_PROG, FCD_OP_PROT_LOCK, FCD_OP_SET_CONFIG: is_two_cycle = 1'b1;
      default: is_two_cycle = 1'b0;
    endcase
  endfunction

  // only assigned codes ever leave the host
  function automatic logic [7:0] first_code(input logic [3:0] op, input logic alt);
    unique case (op)
      FCD_OP_READ_ARRAY:  first_code = FCD_CMD_READ_ARRAY;
      FCD_OP_READ_STATUS: first_code = FCD_CMD_READ_STATUS;
      FCD_OP_READ_ID:     first_code = FCD_CMD_READ_ID;
      FCD_OP_READ_QUERY:  first_code = FCD_CMD_READ_QUERY;
      FCD_OP_CLEAR:       first_code = FCD_CMD_CLEAR_STATUS;
      FCD_OP_PROGRAM:     first_code = alt ? FCD_CMD_PROG_ALT : FCD_CMD_PROG_SETUP;
      FCD_OP_ERASE:       first_code = FCD_CMD_ERASE_SETUP;
      FCD_OP_SUSPEND:     first_code = FCD_CMD_SUSPEND;
      FCD_OP_RESUME:      first_code = FCD_CMD_CONFIRM;
      FCD_OP_LOCK, FCD_OP_UNLOCK, FCD_OP_LOCK_DOWN,
      FCD_OP_SET_CONFIG:  first_code = FCD_CMD_LOCK_SETUP;
      FCD_OP_PROT_PROG, FCD_OP_PROT_LOCK: first_code = FCD_CMD_PROT_SETUP;
      default:            first_code = FCD_CMD_READ_ARRAY;
    endcase
  endfunction

  function automatic logic [FCD_DW-1:0] second_data(input logic [3:0] op, input logic [FCD_DW-1:0] d);
    unique case (op)
      FCD_OP_ERASE:      second_data = {8'h00, FCD_CMD_CONFIRM};
      FCD_OP_LOCK:       second_data = {8'h00, FCD_CMD_LOCK_BLOCK};
      FCD_OP_UNLOCK:     second_data = {8'h00, FCD_CMD_CONFIRM};
      FCD_OP_LOCK_DOWN:  second_data = {8'h00, FCD_CMD_LOCK_DOWN};
      FCD_OP_SET_CONFIG: second_data = {8'h00, FCD_CMD_SET_CONFIG};
      FCD_OP_PROT_LOCK:  second_data = FCD_PROT_LOCK_VALUE;
      default:           second_data = d;
    endcase
  endfunction

  // target address of both cycles
  function automatic logic [FCD_AW-1:0] target_addr(input logic [3:0] op, input logic [FCD_AW-1:0] a,
                                                    input logic [FCD_DW-1:0] d);
    unique case (op)
      FCD_OP_PROT_LOCK:  target_addr = FCD_LOCK_PROT_ADDR;
      FCD_OP_PROT_PROG:  target_addr = FCD_PROT_WORD_BASE + {22'h0, a[1:0]};
      FCD_OP_SET_CONFIG: target_addr = {a[FCD_AW-1:FCD_DW], d};
      default:           target_addr = a;
    endcase
  endfunction

  // ==========================================================================
  // sequencer state
  fcd_state_t        state_ff, nxt_state;
  logic [3:0]        op_ff, nxt_op;
  logic [FCD_AW-1:0] addr_ff, nxt_addr;
  logic [FCD_DW-1:0] data_ff, nxt_data;
  logic              busy_ff, nxt_busy;
  logic              done_ff, nxt_done;
  logic              refused_ff, nxt_refused;
  logic              array_ok_ff, nxt_array_ok;
  logic              dev_busy_ff, nxt_dev_busy;
  logic              wr_start;
  logic [FCD_AW-1:0] wr_addr;
  logic [FCD_DW-1:0] wr_data;
  logic              wr_done;
  logic              op_ok;

  // busy partition takes only status reads and suspend
  assign op_ok = !dev_busy_ff || (op_i == FCD_OP_READ_STATUS) || (op_i == FCD_OP_SUSPEND);

  always_comb begin
    nxt_state    = state_ff;
    nxt_op       = op_ff;
    nxt_addr     = addr_ff;
    nxt_data     = data_ff;
    nxt_busy     = busy_ff;
    nxt_done     = 1'b0;
    nxt_refused  = 1'b0;
    nxt_array_ok = array_ok_ff;
    nxt_dev_busy = dev_busy_ff;
    wr_start     = 1'b0;
    wr_addr      = addr_ff;
    wr_data      = {8'h00, first_code(op_ff, 1'b0)};
    unique case (state_ff)
      FCD_ST_IDLE: begin
        if (req_i && op_ok) begin
          nxt_op    = op_i;
          nxt_addr  = target_addr(op_i, addr_i, data_i);
          nxt_data  = second_data(op_i, data_i);
          nxt_busy  = 1'b1;
          nxt_state = FCD_ST_CYC1;
          wr_start  = 1'b1;
          wr_addr   = target_addr(op_i, addr_i, data_i);
          wr_data   = {8'h00, first_code(op_i, alt_setup_i)};
        end else if (req_i) begin
          nxt_refused = 1'b1;
        end
      end
      FCD_ST_CYC1: begin
        // the second write follows directly; no other write may slip in between
        if (wr_done) begin
          if (is_two_cycle(op_ff)) begin
            nxt_state = FCD_ST_CYC2;
            wr_start  = 1'b1;
            wr_data   = data_ff;
          end else begin
            nxt_state = FCD_ST_DONE;
          end
        end
      end
      FCD_ST_CYC2: begin
        if (wr_done) begin
          nxt_state = FCD_ST_DONE;
        end
      end
      FCD_ST_DONE: begin
        nxt_busy  = 1'b0;
        nxt_done  = 1'b1;
        nxt_state = FCD_ST_IDLE;
        unique case (op_ff)
          FCD_OP_PROGRAM, FCD_OP_ERASE, FCD_OP_PROT_PROG, FCD_OP_PROT_LOCK: begin
            nxt_array_ok = 1'b0;
            nxt_dev_busy = 1'b1;
          end
          FCD_OP_SUSPEND: nxt_dev_busy = 1'b0;
          FCD_OP_RESUME:  nxt_dev_busy = 1'b1;
          // host has no status read-back; read-array restores array view and clears busy
          FCD_OP_READ_ARRAY: begin
            nxt_array_ok = 1'b1;
            nxt_dev_busy = 1'b0;
          end
          default: ;
        endcase
      end
      default: nxt_state = FCD_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_ff    <= FCD_ST_IDLE;
      op_ff       <= FCD_OP_READ_ARRAY;
      addr_ff     <= FCD_ZERO24;
      data_ff     <= FCD_ZERO16;
      busy_ff     <= 1'b0;
      done_ff     <= 1'b0;
      refused_ff  <= 1'b0;
      array_ok_ff <= 1'b1;
      dev_busy_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      op_ff       <= nxt_op;
      addr_ff     <= nxt_addr;
      data_ff     <= nxt_data;
      busy_ff     <= nxt_busy;
      done_ff     <= nxt_done;
      refused_ff  <= nxt_refused;
      array_ok_ff <= nxt_array_ok;
      dev_busy_ff <= nxt_dev_busy;
    end
  end

  // ==========================================================================
  // pin driver
  fcd_write_cycle u_wr (
    .clk_i             (clk_i),
    .resetn_i          (resetn_i),
    .start_i           (wr_start),
    .addr_i            (wr_addr),
    .data_i            (wr_data),
    .done_o            (wr_done),
    .ce_n_o            (ce_n_o),
    .we_n_o            (we_n_o),
    .oe_n_o            (oe_n_o),
    .address_valid_n_o (address_valid_n_o),
    .adq_o             (adq_o),
    .adq_oe_n_o        (adq_oe_n_o)
  );

  assign busy_o     = busy_ff;
  assign done_o     = done_ff;
  assign refused_o  = refused_ff;
  assign array_ok_o = array_ok_ff;

endmodule

// [dv/fcd_host_sva.sv]
// ============================================================================
// pin timing checker for the flash command sequencer
module fcd_host_sva
  import fcd_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // status
  input  wire logic              busy_o,
  input  wire logic              done_o,
  input  wire logic              refused_o,
  // flash pins
  input  wire logic              ce_n_o,
  input  wire logic              we_n_o,
  input  wire logic              oe_n_o,
  input  wire logic              address_valid_n_o,
  input  wire logic [FCD_AW-1:0] adq_o,
  input  wire logic              adq_oe_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // ==========================================================================
  // upper address seen in the address phase, reused in the data phase
  logic [7:0] hi_ff;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      hi_ff <= 8'h00;
    end else if (!address_valid_n_o) begin
      hi_ff <= adq_o[23:16];
    end
  end

  // ==========================================================================
  // write cycle shape
  sequence s_addr_phase;
    !address_valid_n_o && !ce_n_o && we_n_o && !adq_oe_n_o;
  endsequence
  sequence s_data_phase;
    (address_valid_n_o && !we_n_o) [*2] ##1 we_n_o;
  endsequence

  a_ce_starts: assert property ($fell(ce_n_o) |-> s_addr_phase)
    else $error("chip enable fell without an address phase");
  a_write_shape: assert property ($fell(address_valid_n_o) |=> s_data_phase ##1 ce_n_o)
    else $error("write cycle strobes out of order");
  a_ce_hold: assert property ($fell(we_n_o) |-> !ce_n_o [*3] ##1 (ce_n_o && adq_oe_n_o))
    else $error("chip enable not held around write enable");
  a_upper_addr: assert property (!we_n_o |-> adq_o[23:16] == hi_ff)
    else $error("upper address changed in data phase");
  a_data_stable: assert property ((!we_n_o && !$past(we_n_o)) |-> $stable(adq_o))
    else $error("bus changed while write enable low");
  a_oe_off: assert property (oe_n_o)
    else $error("output enable asserted");
  a_quiet_idle: assert property (!busy_o |-> ce_n_o && adq_oe_n_o)
    else $error("bus driven while idle");
  // a new request may be taken on the very next edge, so only the refusal cycle itself is quiet
  a_refuse_quiet: assert property (refused_o |-> (ce_n_o && adq_oe_n_o && !busy_o))
    else $error("write issued for a refused request");
  a_done_pulse: assert property (done_o |-> ce_n_o && we_n_o ##1 !done_o)
    else $error("done not a single idle pulse");
endmodule

bind fcd_host fcd_host_sva chk_u (
  .clk_i(clk_i), .resetn_i(resetn_i), .busy_o(busy_o), .done_o(done_o), .refused_o(refused_o),
  .ce_n_o(ce_n_o), .we_n_o(we_n_o), .oe_n_o(oe_n_o), .address_valid_n_o(address_valid_n_o),
  .adq_o(adq_o), .adq_oe_n_o(adq_oe_n_o)
);

// [dv/fcd_dev_model.sv]
// ============================================================================
// behavioural flash command decoder seen from the pins
module fcd_dev_model
  import fcd_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // flash pins
  input  wire logic              ce_n_i,
  input  wire logic              we_n_i,
  input  wire logic              oe_n_i,
  input  wire logic              address_valid_n_i,
  input  wire logic [FCD_AW-1:0] adq_i,
  input  wire logic              adq_oe_n_i,
  // observed write cycles
  output logic                   wr_ev_o,
  output logic [FCD_AW-1:0]      wr_addr_o,
  output logic [FCD_DW-1:0]      wr_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [FCD_AW-1:0] bus, a_ff;
  logic [7:0]        pend_ff, status_ff, mode_ff, code;
  logic [1:0]        lock_ff [256];
  logic [15:0]       cfg_ff;
  logic              busy_ff, susp_ff, seq_err_ff, we_d_ff;
  // a released bus shows garbage, never the last driven value
  assign bus  = adq_oe_n_i ? ~adq_i : adq_i;
  assign code = bus[7:0];

  // ==========================================================================
  // decoder
  always_ff @(posedge clk_i) begin
    wr_ev_o <= 1'b0;
    we_d_ff <= we_n_i;
    if (!resetn_i) begin
      pend_ff    <= 8'h00;
      status_ff  <= 8'h80;
      busy_ff    <= 1'b0;
      susp_ff    <= 1'b0;
      seq_err_ff <= 1'b0;
    end else begin
      if (!ce_n_i && !address_valid_n_i) a_ff <= bus;
      if (!ce_n_i && oe_n_i && we_n_i && !we_d_ff) begin
        wr_ev_o   <= 1'b1;
        wr_addr_o <= a_ff;
        wr_data_o <= bus[15:0];
        pend_ff   <= 8'h00;
        if (pend_ff == FCD_CMD_LOCK_SETUP) begin
          case (code)
            FCD_CMD_LOCK_BLOCK: lock_ff[a_ff[23:16]][0] <= 1'b1;
            FCD_CMD_CONFIRM: if (lock_ff[a_ff[23:16]][1] !== 1'b1) lock_ff[a_ff[23:16]][0] <= 1'b0;
            FCD_CMD_LOCK_DOWN: lock_ff[a_ff[23:16]] <= 2'b11;
            FCD_CMD_SET_CONFIG: cfg_ff <= a_ff[15:0];
            default: begin
              status_ff[5:4] <= 2'b11;
              seq_err_ff     <= 1'b1;
            end
          endcase
        end else if (pend_ff inside {FCD_CMD_PROT_SETUP, FCD_CMD_PROG_SETUP, FCD_CMD_PROG_ALT}) begin
          busy_ff <= 1'b1;
        end else if (pend_ff == FCD_CMD_ERASE_SETUP) begin
          if (code == FCD_CMD_CONFIRM) busy_ff <= 1'b1;
          else seq_err_ff <= 1'b1;
        end else if (busy_ff && code != FCD_CMD_READ_STATUS && code != FCD_CMD_SUSPEND) begin
          seq_err_ff <= 1'b1;
        end else begin
          case (code)
            FCD_CMD_LOCK_SETUP, FCD_CMD_PROT_SETUP, FCD_CMD_PROG_SETUP, FCD_CMD_PROG_ALT,
            FCD_CMD_ERASE_SETUP: pend_ff <= code;
            FCD_CMD_CLEAR_STATUS: status_ff <= status_ff & 8'hc5;
            FCD_CMD_SUSPEND: begin
              busy_ff <= 1'b0;
              susp_ff <= busy_ff;
            end
            FCD_CMD_CONFIRM: if (susp_ff) begin
              busy_ff <= 1'b1;
              susp_ff <= 1'b0;
            end
            FCD_CMD_READ_ARRAY, FCD_CMD_READ_STATUS, FCD_CMD_READ_ID,
            FCD_CMD_READ_QUERY: mode_ff <= code;
            default: seq_err_ff <= 1'b1;
          endcase
        end
      end
    end
  end
endmodule

// [dv/tb.sv]
module tb
  import fcd_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // signals
  logic              clk_i, resetn_i, req_i, alt_setup_i, wr_ev, dev_busy, ok_exp;
  logic [3:0]        op_i;
  logic [FCD_AW-1:0] addr_i, adq_o, wr_addr;
  logic [FCD_DW-1:0] data_i, wr_data;
  logic              busy_o, done_o, refused_o, array_ok_o;
  logic              ce_n_o, we_n_o, oe_n_o, address_valid_n_o, adq_oe_n_o;
  logic [1:0]        note;
  logic [39:0]       wq [$];
  logic [1:0]        oq [$];
  logic [31:0]       lfsr_ff;
  int                errors, n_checks;
  logic [7:0]        first_code [15] = '{FCD_CMD_READ_ARRAY, FCD_CMD_READ_STATUS, FCD_CMD_READ_ID,
    FCD_CMD_READ_QUERY, FCD_CMD_CLEAR_STATUS, FCD_CMD_PROG_SETUP, FCD_CMD_ERASE_SETUP, FCD_CMD_SUSPEND,
    FCD_CMD_CONFIRM, FCD_CMD_LOCK_SETUP, FCD_CMD_LOCK_SETUP, FCD_CMD_LOCK_SETUP, FCD_CMD_PROT_SETUP,
    FCD_CMD_PROT_SETUP, FCD_CMD_LOCK_SETUP};
  // every op at least once, with refusals while busy and suspend/resume mixed in
  logic [3:0]        seq_ops [27] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h9, 4'hA, 4'hB, 4'hA, 4'hE, 4'h5, 4'h1,
    4'h6, 4'h7, 4'h8, 4'h4, 4'h7, 4'h0, 4'h6, 4'h7, 4'hC, 4'h7, 4'hD, 4'h7, 4'h0, 4'h5, 4'h7};

  fcd_host dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i), .op_i(op_i), .addr_i(addr_i),
    .data_i(data_i), .alt_setup_i(alt_setup_i), .busy_o(busy_o), .done_o(done_o), .refused_o(refused_o),
    .array_ok_o(array_ok_o), .ce_n_o(ce_n_o), .we_n_o(we_n_o), .oe_n_o(oe_n_o),
    .address_valid_n_o(address_valid_n_o), .adq_o(adq_o), .adq_oe_n_o(adq_oe_n_o));
  fcd_dev_model dev_u (.clk_i(clk_i), .resetn_i(resetn_i), .ce_n_i(ce_n_o), .we_n_i(we_n_o), .oe_n_i(oe_n_o),
    .address_valid_n_i(address_valid_n_o), .adq_i(adq_o), .adq_oe_n_i(adq_oe_n_o), .wr_ev_o(wr_ev),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data));

  // ==========================================================================
  // helpers
  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic finish_test();
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // expected pin writes are queued before the request goes out
  task automatic do_op(input logic [3:0] op, input logic [23:0] a, input logic [15:0] d, input logic alt);
    logic        refuse;
    logic [23:0] pa;
    logic [15:0] c1, c2;
    int          n;
    refuse = dev_busy && op != FCD_OP_READ_STATUS && op != FCD_OP_SUSPEND;
    pa = (op == FCD_OP_PROT_PROG) ? FCD_PROT_WORD_BASE + 24'(a[1:0]) : (op == FCD_OP_PROT_LOCK) ?
      FCD_LOCK_PROT_ADDR : (op == FCD_OP_SET_CONFIG) ? {a[23:16], d} : a;
    c1 = {8'h00, (op == FCD_OP_PROGRAM && alt) ? FCD_CMD_PROG_ALT : first_code[op]};
    case (op)
      FCD_OP_PROGRAM, FCD_OP_PROT_PROG: c2 = d;
      FCD_OP_ERASE, FCD_OP_UNLOCK: c2 = {8'h00, FCD_CMD_CONFIRM};
      FCD_OP_LOCK: c2 = {8'h00, FCD_CMD_LOCK_BLOCK};
      FCD_OP_LOCK_DOWN: c2 = {8'h00, FCD_CMD_LOCK_DOWN};
      FCD_OP_PROT_LOCK: c2 = FCD_PROT_LOCK_VALUE;
      default: c2 = {8'h00, FCD_CMD_SET_CONFIG};
    endcase
    if (!refuse) begin
      wq.push_back({pa, c1});
      if (op inside {FCD_OP_PROGRAM, FCD_OP_ERASE, [FCD_OP_LOCK:FCD_OP_SET_CONFIG]}) wq.push_back({pa, c2});
      if (op inside {FCD_OP_PROGRAM, FCD_OP_ERASE, FCD_OP_PROT_PROG, FCD_OP_PROT_LOCK, FCD_OP_RESUME}) dev_busy = 1;
      if (op inside {FCD_OP_SUSPEND, FCD_OP_READ_ARRAY}) dev_busy = 0;
      if (op inside {FCD_OP_PROGRAM, FCD_OP_ERASE, FCD_OP_PROT_PROG, FCD_OP_PROT_LOCK}) ok_exp = 0;
      if (op == FCD_OP_READ_ARRAY) ok_exp = 1;
    end
    oq.push_back({refuse, ok_exp});
    req_i = 1'b1;
    op_i = op;
    addr_i = a;
    data_i = d;
    alt_setup_i = alt;
    @(negedge clk_i);
    req_i = 1'b0;
    for (n = 0; n < 40 && done_o !== 1'b1 && refused_o !== 1'b1; n++) @(negedge clk_i);
    if (n >= 40) check("completion", 40'h0, 40'h1);
    @(negedge clk_i);
  endtask

  // ==========================================================================
  // result watchers
  always @(negedge clk_i) begin
    if (wr_ev === 1'b1) begin
      if (wq.size() == 0) check("write count", 40'h1, 40'h0);
      else check("write", {wr_addr, wr_data}, wq.pop_front());
    end
  end
  initial forever begin
    @(negedge clk_i);
    if ((done_o === 1'b1 || refused_o === 1'b1) && oq.size() > 0) begin
      note = oq.pop_front();
      check("refused", 40'(refused_o), 40'(note[1]));
      @(negedge clk_i);
      check("array ok", 40'(array_ok_o), 40'(note[0]));
    end
  end

  // ==========================================================================
  // clock, watchdog and main sequence
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    #200_000;
    errors++;
    finish_test();
  end
  initial begin
    {resetn_i, req_i, alt_setup_i, op_i, addr_i, data_i} = '0;
    {dev_busy, ok_exp, errors, n_checks} = {2'b01, 64'h0};
    lfsr_ff = 32'h0000_c0be;
    repeat (3) @(negedge clk_i);
    resetn_i = 1'b1;
    check("idle pins", 40'({ce_n_o, we_n_o, oe_n_o, address_valid_n_o, adq_oe_n_o, busy_o}), 40'h3e);
    for (int i = 0; i < 60; i++) begin
      lfsr_ff = lfsr(lfsr_ff);
      do_op((i < 27) ? seq_ops[i] : 4'(lfsr_ff[7:0] % 8'd15), lfsr_ff[31:8], lfsr_ff[23:8], lfsr_ff[3]);
    end
    // reset in the middle of a write leaves nothing pending
    req_i = 1'b1;
    op_i = FCD_OP_ERASE;
    repeat (3) @(negedge clk_i);
    {resetn_i, req_i} = 2'b00;
    @(negedge clk_i);
    check("reset pins", 40'({ce_n_o, we_n_o, address_valid_n_o, adq_oe_n_o, busy_o, done_o}), 40'h3c);
    resetn_i = 1'b1;
    {dev_busy, ok_exp} = 2'b01;
    do_op(FCD_OP_PROT_LOCK, lfsr_ff[23:0], lfsr_ff[15:0], 1'b0);
    check("writes left", 40'(wq.size()), 40'h0);
    check("sequence error", 40'(dev_u.seq_err_ff), 40'h0);
    check("status flags", 40'(dev_u.status_ff[5:4]), 40'h0);
    finish_test();
  end
endmodule
